// ===== hw/parity_calc.sv
`timescale 1ns/1ps
module parity_calc (
   input wire logic [7:0] data,
   input wire logic [1:0] wlen,
   input wire uart_pkg::parity_mode_t mode,
   output logic bit_out,
   output logic enable
);
   logic [7:0] mask;
   logic odd_ones;

   always_comb begin
      mask = 8'hFF >> (2'h3 - wlen);
      odd_ones = ^(data & mask);
      enable = (mode != uart_pkg::parity_off);
      case (mode)
         uart_pkg::parity_even_sel: bit_out = odd_ones;
         uart_pkg::parity_odd_sel: bit_out = ~odd_ones;
         uart_pkg::parity_forced_one: bit_out = 1'h1;
         default: bit_out = 1'h0;
      endcase
   end
endmodule

// ===== hw/uart_cfg.svh
`ifndef UART_CFG_SVH
`define UART_CFG_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_CTRL 5'h00
`define OFS_ERR 5'h04
`define OFS_IMASK 5'h08
`define OFS_RIS 5'h0C
`define OFS_MIS 5'h10
`define OFS_ICR 5'h14
`define OFS_STAT 5'h18

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CTRL_SMART_BIT 5
`define CTRL_W 7
`define STAT_SPACE_BIT 0
`define STAT_IDLE_BIT 1
`define IRQ_W 11
`define IRQ_RX 4
`define IRQ_TX 5
`define IRQ_RT 6
`define IRQ_FE 7
`define IRQ_PE 8
`define IRQ_BE 9
`define IRQ_OE 10

// ----------------------------------------------------------------
// Reset values and fixed counts
// ----------------------------------------------------------------
`define CTRL_RST 7'h00
`define IMASK_RST 11'h000
`define WLEN_EIGHT 2'h3
`define WLEN_BASE 4'h5
`define LINE_IDLE 1'h1

`endif

// ===== hw/uart_parity_error_txint_logic.sv
// Overview of operation
// [RULE_01] Parity is none, even, odd, forced one or forced zero; forced modes send a fixed bit.
// [RULE_02] The one parity setting drives both the sent parity bit and the parity checked on receive.
// [RULE_03] Framing, parity, break and overrun flags are kept and read together as one word.
// [RULE_04] Flags follow the per-character error bits, but overrun is flagged the moment it occurs.
// [RULE_05] One write clears all four receive error flags at once.
// [RULE_06] Software clears the error flags after clearing an error interrupt so the next one fires.
// [RULE_07] Enabling smart card mode sets its bit and forces 8-bit words with even parity.
// [RULE_08] Disabling smart card mode clears the smart card bit and returns to plain operation.
// [RULE_09] A status bit is true while the transmit FIFO has a free entry and false when it is full.
// [RULE_10] By default the transmit interrupt fires when the FIFO level falls past the threshold.
// [RULE_11] In idle mode the transmit interrupt fires once the FIFO is empty and the shifter done.
// [RULE_12] The transmit interrupt mode is both writable and readable.
// [RULE_13] Eleven interrupt sources are enabled one by one and only enabled ones reach the output.
// [RULE_14] Interrupt status reads both raw and masked by the enables.
// [RULE_15] Break is flagged when the line stays low longer than one whole character frame.
// [RULE_16] The error clear leaves the receive data, enables and transmit interrupt mode alone.
`timescale 1ns/1ps
`include "uart_cfg.svh"
module uart_parity_error_txint_logic (
   input wire logic clk,
   input wire logic srst,
   input wire logic ce,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output uart_pkg::ctrl_t line_fmt,
   input wire logic [7:0] tx_char,
   output logic tx_parity_bit,
   output logic tx_parity_en,
   input wire logic rx_pin,
   input wire logic bit_tick,
   input wire logic rx_char_valid,
   input wire logic [7:0] rx_char_data,
   input wire logic rx_char_par,
   input wire logic rx_char_stop_ok,
   input wire logic rx_fifo_full,
   output uart_pkg::rx_char_t rx_word,
   output logic rx_word_valid,
   input wire logic [4:0] tx_fifo_level,
   input wire logic [4:0] tx_fifo_thr,
   input wire logic tx_fifo_full,
   input wire logic tx_shift_busy,
   input wire logic rx_level_evt,
   input wire logic rx_timeout_irq,
   input wire logic [3:0] modem_chg,
   output logic tx_space_avail,
   output logic irq
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic hit(input logic [4:0] addr, input logic [4:0] ofs);
      hit = (addr == ofs);
   endfunction

   uart_pkg::ctrl_t ctrl_r;
   uart_pkg::rx_err_t err_r;
   uart_pkg::rx_char_t rxw_r;
   logic [`IRQ_W-1:0] imask_r, ris_r;
   logic [31:0] rdata_r;
   logic [3:0] brk_cnt_r;
   logic [4:0] lvl_r;
   logic wait_r, rx_meta_r, rx_s_r, brk_armed_r, ovr_pend_r, idle_r;
   logic space_r, irq_r, txp_bit_r, txp_en_r, rxw_v_r;

   logic req, acc, err_clr, ctrl_wr, icr_wr;
   logic tx_exp_bit, tx_exp_en, rx_exp_bit, rx_exp_en;
   uart_pkg::rx_err_t ch_err, err_set;
   logic brk_fire, tx_idle, tx_evt;
   logic [3:0] frame_bits;
   logic [`IRQ_W-1:0] evt;

   assign req = avs_read | avs_write;
   assign acc = ce & req & ~wait_r;
   assign err_clr = acc & avs_write & hit(avs_address, `OFS_ERR);
   assign ctrl_wr = acc & avs_write & hit(avs_address, `OFS_CTRL);
   assign icr_wr = acc & avs_write & hit(avs_address, `OFS_ICR);

   // ----------------------------------------------------------------
   // Bus slave
   // ----------------------------------------------------------------
   // Each request waits one cycle; read data is captured on the first edge so it stands
   // stable at the completing edge.
   always_ff @(posedge clk) begin
      if (srst) begin
         wait_r <= 1'h1;
      end else if (ce) begin
         wait_r <= ~(req & wait_r);
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         rdata_r <= 32'h0000_0000;
      end else if (ce && req && wait_r) begin
         rdata_r <= 32'h0000_0000;
         if (avs_read) begin
            case (avs_address)
               `OFS_CTRL: rdata_r[`CTRL_W-1:0] <= ctrl_r; // RULE_12
               `OFS_ERR: rdata_r[3:0] <= err_r; // RULE_03
               `OFS_IMASK: rdata_r[`IRQ_W-1:0] <= imask_r;
               `OFS_RIS: rdata_r[`IRQ_W-1:0] <= ris_r; // RULE_14
               `OFS_MIS: rdata_r[`IRQ_W-1:0] <= ris_r & imask_r; // RULE_14
               `OFS_STAT: rdata_r[1:0] <= {idle_r, space_r};
               default: rdata_r <= 32'h0000_0000;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // Control register
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         ctrl_r <= `CTRL_RST;
      end else if (ce && ctrl_wr) begin
         ctrl_r.txmode <= uart_pkg::txirq_mode_t'(avs_writedata[`CTRL_W-1]); // RULE_12
         ctrl_r.smart <= avs_writedata[`CTRL_SMART_BIT]; // RULE_08
         if (avs_writedata[`CTRL_SMART_BIT]) begin
            ctrl_r.wlen <= `WLEN_EIGHT; // RULE_07
            ctrl_r.par <= uart_pkg::parity_even_sel; // RULE_07
         end else begin
            ctrl_r.wlen <= avs_writedata[4:3];
            if (avs_writedata[2:0] > 3'(uart_pkg::parity_forced_zero)) begin
               ctrl_r.par <= uart_pkg::parity_off;
            end else begin
               ctrl_r.par <= uart_pkg::parity_mode_t'(avs_writedata[2:0]); // RULE_01
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         imask_r <= `IMASK_RST;
      end else if (ce && acc && avs_write && hit(avs_address, `OFS_IMASK)) begin
         imask_r <= avs_writedata[`IRQ_W-1:0];
      end
   end

   // ----------------------------------------------------------------
   // Parity generation and checking
   // ----------------------------------------------------------------
   parity_calc tx_par (.data(tx_char), .wlen(ctrl_r.wlen), .mode(ctrl_r.par),
      .bit_out(tx_exp_bit), .enable(tx_exp_en));

   parity_calc rx_par (.data(rx_char_data), .wlen(ctrl_r.wlen), .mode(ctrl_r.par),
      .bit_out(rx_exp_bit), .enable(rx_exp_en));

   always_ff @(posedge clk) begin
      if (srst) begin
         txp_bit_r <= 1'h0;
         txp_en_r <= 1'h0;
      end else if (ce) begin
         txp_bit_r <= tx_exp_bit; // RULE_01 RULE_02
         txp_en_r <= tx_exp_en;
      end
   end

   always_comb begin
      ch_err.rx_frame_err_flag = ~rx_char_stop_ok;
      ch_err.rx_parity_err_flag = rx_exp_en & (rx_char_par != rx_exp_bit); // RULE_02
      ch_err.rx_break_err_flag = ~rx_char_stop_ok & ~rx_char_par & (rx_char_data == 8'h00);
      ch_err.rx_overrun_err_flag = ovr_pend_r;
   end

   // A character dropped on a full FIFO marks the next delivered one with overrun.
   always_ff @(posedge clk) begin
      if (srst) begin
         rxw_r <= '0;
         rxw_v_r <= 1'h0;
         ovr_pend_r <= 1'h0;
      end else if (ce) begin
         rxw_v_r <= rx_char_valid & ~rx_fifo_full;
         if (rx_char_valid && !rx_fifo_full) begin
            rxw_r <= {ch_err, rx_char_data};
            ovr_pend_r <= 1'h0;
         end else if (rx_char_valid) begin
            ovr_pend_r <= 1'h1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Break detection on the line
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         rx_meta_r <= `LINE_IDLE;
         rx_s_r <= `LINE_IDLE;
      end else if (ce) begin
         rx_meta_r <= rx_pin;
         rx_s_r <= rx_meta_r;
      end
   end

   // Start, data, parity and stop bits make one frame.
   assign frame_bits = 4'h2 + `WLEN_BASE + {2'h0, ctrl_r.wlen} + {3'h0, rx_exp_en};
   assign brk_fire = bit_tick & ~rx_s_r & brk_armed_r & (brk_cnt_r == frame_bits); // RULE_15

   always_ff @(posedge clk) begin
      if (srst) begin
         brk_cnt_r <= 4'h0;
         brk_armed_r <= 1'h1;
      end else if (ce) begin
         if (rx_s_r) begin
            brk_cnt_r <= 4'h0;
            brk_armed_r <= 1'h1;
         end else if (bit_tick) begin
            if (brk_cnt_r != 4'hF) begin
               brk_cnt_r <= brk_cnt_r + 4'h1;
            end
            if (brk_fire) begin
               brk_armed_r <= 1'h0;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Receive error flags
   // ----------------------------------------------------------------
   always_comb begin
      err_set = '0;
      if (rx_char_valid && !rx_fifo_full) begin
         err_set = ch_err; // RULE_04
         err_set.rx_overrun_err_flag = 1'h0;
      end
      err_set.rx_overrun_err_flag = rx_char_valid & rx_fifo_full; // RULE_04
      err_set.rx_break_err_flag = err_set.rx_break_err_flag | brk_fire; // RULE_15
   end

   // A new error wins over a clear in the same cycle; the clear touches nothing else.
   always_ff @(posedge clk) begin
      if (srst) begin
         err_r <= '0;
      end else if (ce) begin
         err_r <= (err_clr ? uart_pkg::rx_err_t'(4'h0) : err_r) | err_set; // RULE_05 RULE_16
      end
   end

   // ----------------------------------------------------------------
   // Transmit side status
   // ----------------------------------------------------------------
   assign tx_idle = (tx_fifo_level == 5'h00) & ~tx_shift_busy;

   always_ff @(posedge clk) begin
      if (srst) begin
         space_r <= 1'h1;
         idle_r <= 1'h1;
         lvl_r <= 5'h00;
      end else if (ce) begin
         space_r <= ~tx_fifo_full; // RULE_09
         idle_r <= tx_idle;
         lvl_r <= tx_fifo_level;
      end
   end

   always_comb begin
      if (ctrl_r.txmode == uart_pkg::txirq_on_idle) begin
         tx_evt = tx_idle & ~idle_r; // RULE_11
      end else begin
         tx_evt = (lvl_r > tx_fifo_thr) & (tx_fifo_level <= tx_fifo_thr); // RULE_10
      end
   end

   // ----------------------------------------------------------------
   // Interrupt status
   // ----------------------------------------------------------------
   // Error interrupts fire only when a flag goes from clear to set or an error meets a clear write,
   // so a flag left set hides repeats of the same error.
   always_comb begin
      evt = '0;
      evt[3:0] = modem_chg;
      evt[`IRQ_RX] = rx_level_evt;
      evt[`IRQ_TX] = tx_evt;
      evt[`IRQ_RT] = rx_timeout_irq;
      evt[`IRQ_FE] = err_set.rx_frame_err_flag & (~err_r.rx_frame_err_flag | err_clr);
      evt[`IRQ_PE] = err_set.rx_parity_err_flag & (~err_r.rx_parity_err_flag | err_clr);
      evt[`IRQ_BE] = err_set.rx_break_err_flag & (~err_r.rx_break_err_flag | err_clr);
      evt[`IRQ_OE] = err_set.rx_overrun_err_flag & (~err_r.rx_overrun_err_flag | err_clr);
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         ris_r <= '0;
      end else if (ce) begin
         ris_r <= (icr_wr ? ris_r & ~avs_writedata[`IRQ_W-1:0] : ris_r) | evt; // RULE_13
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         irq_r <= 1'h0;
      end else if (ce) begin
         irq_r <= |(ris_r & imask_r); // RULE_13
      end
   end

   assign avs_readdata = rdata_r;
   assign avs_waitrequest = wait_r;
   assign line_fmt = ctrl_r;
   assign tx_parity_bit = txp_bit_r;
   assign tx_parity_en = txp_en_r;
   assign rx_word = rxw_r;
   assign rx_word_valid = rxw_v_r;
   assign tx_space_avail = space_r;
   assign irq = irq_r;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   sequence smart_on_write_s;
      ce && ctrl_wr && avs_writedata[`CTRL_SMART_BIT];
   endsequence
   sequence smart_off_write_s;
      ce && ctrl_wr && !avs_writedata[`CTRL_SMART_BIT];
   endsequence
   forced_one_bit_a: assert property ( // RULE_01
      ce && ctrl_r.par == uart_pkg::parity_forced_one |=> tx_parity_bit && tx_parity_en)
      else $error("forced one parity not sent");
   rx_parity_flag_a: assert property ( // RULE_02
      ce && rx_char_valid && !rx_fifo_full && rx_exp_en && rx_char_par != rx_exp_bit
      |=> rx_word_valid && rx_word.err.rx_parity_err_flag && err_r.rx_parity_err_flag)
      else $error("parity mismatch not reported");
   err_readback_a: assert property ( // RULE_03
      ce && wait_r && avs_read && hit(avs_address, `OFS_ERR)
      |=> avs_readdata == {28'h0000000, $past(err_r)})
      else $error("error flags read wrong");
   overrun_now_a: assert property ( // RULE_04
      ce && rx_char_valid && rx_fifo_full |=> err_r.rx_overrun_err_flag ##0 !rx_word_valid)
      else $error("overrun not flagged at once");
   err_clear_all_a: assert property ( // RULE_05
      ce && err_clr && err_set == 4'h0 |=> err_r == 4'h0 && $stable(imask_r))
      else $error("error clear incomplete");
   smart_format_a: assert property ( // RULE_07
      smart_on_write_s |=> ctrl_r.smart && ctrl_r.wlen == `WLEN_EIGHT
      && ctrl_r.par == uart_pkg::parity_even_sel)
      else $error("smart card format not forced");
   smart_off_a: assert property ( // RULE_08
      smart_off_write_s |=> !ctrl_r.smart && !line_fmt.smart)
      else $error("smart card bit not cleared");
   tx_space_a: assert property ( // RULE_09
      ce |=> tx_space_avail == !$past(tx_fifo_full)) else $error("space indication wrong");
   eot_irq_a: assert property ( // RULE_11
      ce && ctrl_r.txmode == uart_pkg::txirq_on_idle && tx_idle && !idle_r
      |=> ris_r[`IRQ_TX])
      else $error("end of transmission interrupt missed");
endmodule

// ===== hw/uart_pkg.sv
package uart_pkg;

   typedef enum logic [2:0] {
      parity_off,
      parity_even_sel,
      parity_odd_sel,
      parity_forced_one,
      parity_forced_zero
   } parity_mode_t;

   typedef enum logic {
      txirq_on_fill_level,
      txirq_on_idle
   } txirq_mode_t;

   typedef struct packed {
      txirq_mode_t txmode;
      logic smart;
      logic [1:0] wlen;
      parity_mode_t par;
   } ctrl_t;

   typedef struct packed {
      logic rx_overrun_err_flag;
      logic rx_break_err_flag;
      logic rx_parity_err_flag;
      logic rx_frame_err_flag;
   } rx_err_t;

   typedef struct packed {
      rx_err_t err;
      logic [7:0] data;
   } rx_char_t;

endpackage

// ===== verification/line_partner.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Remote serial device seen through the receive data path
// ----------------------------------------------------------------
module line_partner #(
   parameter int TICK_DIV = 4
) (
   input wire logic clk,
   input wire logic srst,
   output logic rx_pin,
   output logic bit_tick,
   output logic rx_char_valid,
   output logic [7:0] rx_char_data,
   output logic rx_char_par,
   output logic rx_char_stop_ok
);
   int unsigned div_cnt = 0;
   int unsigned tick_miss = 0;

   initial begin
      rx_pin = 1'b1;
      bit_tick = 1'b0;
      rx_char_valid = 1'b0;
      rx_char_data = 8'h00;
      rx_char_par = 1'b0;
      rx_char_stop_ok = 1'b0;
   end

   always @(posedge clk) begin
      if (srst || div_cnt == TICK_DIV - 1) begin
         div_cnt <= 0;
      end else begin
         div_cnt <= div_cnt + 1;
      end
      bit_tick <= !srst && div_cnt == TICK_DIV - 1;
   end

   // A lost tick is counted instead of waited on forever, so the bench can judge it.
   task automatic wait_tick();
      for (int k = 0; k < 4 * TICK_DIV; k++) begin
         @(posedge clk);
         if (bit_tick === 1'b1) return;
      end
      tick_miss++;
   endtask

   // Sends start, eight data bits LSB first, parity and one stop bit; extra holds
   // the stop level longer, gap delays the start so the far side can answer slowly.
   task automatic send_char(input logic [7:0] d, input logic p, input logic s,
                            input int extra, input int gap);
      repeat (gap) @(posedge clk);
      wait_tick();
      rx_pin <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         wait_tick();
         rx_pin <= d[i];
      end
      wait_tick();
      rx_pin <= p;
      wait_tick();
      rx_pin <= s;
      repeat (extra) wait_tick();
      wait_tick();
      rx_pin <= 1'b1;
      @(posedge clk);
      rx_char_valid <= 1'b1;
      rx_char_data <= d;
      rx_char_par <= p;
      rx_char_stop_ok <= s;
      @(posedge clk);
      // Lines are inverted after the pulse so a late sampler cannot see stale data.
      rx_char_valid <= 1'b0;
      rx_char_data <= ~d;
      rx_char_par <= ~p;
      rx_char_stop_ok <= ~s;
   endtask
endmodule

// ===== verification/uart_parity_error_txint_logic_bench.sv
`timescale 1ns/1ps
`include "uart_cfg.svh"
module uart_parity_error_txint_logic_bench;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic ce = 1'b1;
   logic [4:0] avs_address = 5'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   uart_pkg::ctrl_t line_fmt;
   logic [7:0] tx_char = 8'h00;
   logic tx_parity_bit, tx_parity_en, rx_pin, bit_tick, rx_char_valid;
   logic [7:0] rx_char_data;
   logic rx_char_par, rx_char_stop_ok;
   logic rx_fifo_full = 1'b0;
   uart_pkg::rx_char_t rx_word;
   logic rx_word_valid;
   logic [4:0] tx_fifo_level = 5'h00;
   logic [4:0] tx_fifo_thr = 5'h00;
   logic tx_fifo_full = 1'b0;
   logic tx_shift_busy = 1'b0;
   logic rx_level_evt = 1'b0;
   logic rx_timeout_irq = 1'b0;
   logic [3:0] modem_chg = 4'h0;
   logic tx_space_avail, irq;
   logic [31:0] rd;
   int n_mismatch = 0;
   int num_checks = 0;

   always #2.5 clk = ~clk;

   uart_parity_error_txint_logic u_uart_parity_error_txint_logic (
      .clk(clk), .srst(srst), .ce(ce), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .line_fmt(line_fmt), .tx_char(tx_char),
      .tx_parity_bit(tx_parity_bit), .tx_parity_en(tx_parity_en), .rx_pin(rx_pin),
      .bit_tick(bit_tick), .rx_char_valid(rx_char_valid), .rx_char_data(rx_char_data),
      .rx_char_par(rx_char_par), .rx_char_stop_ok(rx_char_stop_ok),
      .rx_fifo_full(rx_fifo_full), .rx_word(rx_word), .rx_word_valid(rx_word_valid),
      .tx_fifo_level(tx_fifo_level), .tx_fifo_thr(tx_fifo_thr), .tx_fifo_full(tx_fifo_full),
      .tx_shift_busy(tx_shift_busy), .rx_level_evt(rx_level_evt),
      .rx_timeout_irq(rx_timeout_irq), .modem_chg(modem_chg),
      .tx_space_avail(tx_space_avail), .irq(irq));

   line_partner u_line_partner (
      .clk(clk), .srst(srst), .rx_pin(rx_pin), .bit_tick(bit_tick),
      .rx_char_valid(rx_char_valid), .rx_char_data(rx_char_data),
      .rx_char_par(rx_char_par), .rx_char_stop_ok(rx_char_stop_ok));

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic end_sim();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string s);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %0t %s seen %h expected %h", $time, s, seen, exp);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge clk);
   endtask

   // A bus request is held until waitrequest is seen low at a rising edge.
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      int k;
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      for (k = 0; k < 50; k++) begin
         @(posedge clk);
         if (avs_waitrequest === 1'b0) break;
      end
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (k == 50) begin
         check(1'b1, 1'b0, "bus hang");
         end_sim();
      end
   endtask

   task automatic rd_chk(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e,
                         input string s);
      bus(1'b0, a, 32'h0);
      check(rd & m, e, s);
   endtask

   task automatic wait_word();
      int k;
      for (k = 0; k < 200; k++) begin
         @(posedge clk);
         if (rx_word_valid === 1'b1) break;
      end
      if (k == 200) begin
         check(1'b1, 1'b0, "no rx word");
         end_sim();
      end
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      rd_chk(`OFS_CTRL, 32'hFFFFFFFF, 32'h0, "ctrl reset");
      rd_chk(`OFS_ERR, 32'hFFFFFFFF, 32'h0, "err reset");
      bus(1'b1, 5'h1C, 32'h7F);
      rd_chk(5'h1C, 32'hFFFFFFFF, 32'h0, "unmapped read");
      rd_chk(`OFS_CTRL, 32'hFFFFFFFF, 32'h0, "unmapped write ignored");
      check(tx_space_avail, 1'b1, "space after reset");
   endtask

   task automatic t_tx_parity();
      logic [7:0] c;
      logic [1:0] e;
      for (int m = 0; m < 5; m++) begin
         bus(1'b1, `OFS_CTRL, 32'h18 | m);
         for (int j = 0; j < 2; j++) begin
            c = j ? 8'hA7 : 8'hA5;
            tx_char <= c;
            step(3);
            e = m == 0 ? 2'b00 : m == 1 ? {1'b1, ^c} : m == 2 ? {1'b1, ~^c} : {1'b1, m == 3};
            check(tx_parity_en, e[1], "parity enable");
            if (e[1]) check(tx_parity_bit, e[0], "parity bit");
         end
      end
      // Five-bit words: only the low five data bits count, so 0xE1 needs a one.
      bus(1'b1, `OFS_CTRL, 32'h01);
      tx_char <= 8'hE1;
      step(3);
      check(tx_parity_bit, 1'b1, "five bit parity");
   endtask

   task automatic t_smart();
      bus(1'b1, `OFS_CTRL, 32'h22);
      rd_chk(`OFS_CTRL, 32'h7F, 32'h39, "smart forces format");
      check(line_fmt, 7'h39, "smart line format");
      bus(1'b1, `OFS_CTRL, 32'h18);
      rd_chk(`OFS_CTRL, 32'h7F, 32'h18, "smart off");
      bus(1'b1, `OFS_CTRL, 32'h1F);
      rd_chk(`OFS_CTRL, 32'h7F, 32'h18, "bad parity code");
   endtask

   task automatic t_rx_errors();
      bus(1'b1, `OFS_CTRL, 32'h1A);
      bus(1'b1, `OFS_IMASK, 32'h780);
      // Odd parity of 0x0F is one, so a zero parity bit must be refused.
      u_line_partner.send_char(8'h0F, 1'b0, 1'b1, 0, 0);
      wait_word();
      check(rx_word, 12'h20F, "parity err per char");
      rd_chk(`OFS_ERR, 32'hF, 32'h2, "parity flag");
      rd_chk(`OFS_RIS, 32'h780, 32'h100, "parity irq raw");
      check(irq, 1'b1, "parity irq out");
      // Interrupt first, then the flags, or the next error would stay silent.
      bus(1'b1, `OFS_ICR, 32'h780);
      bus(1'b1, `OFS_ERR, 32'h0);
      rd_chk(`OFS_ERR, 32'hF, 32'h0, "all flags cleared");
      check(rx_word, 12'h20F, "word kept");
      rd_chk(`OFS_CTRL, 32'h7F, 32'h1A, "ctrl kept");
      rd_chk(`OFS_IMASK, 32'h7FF, 32'h780, "mask kept");
      u_line_partner.send_char(8'h0F, 1'b0, 1'b1, 0, 7);
      wait_word();
      rd_chk(`OFS_RIS, 32'h780, 32'h100, "parity irq again");
      bus(1'b1, `OFS_ICR, 32'h780);
      bus(1'b1, `OFS_ERR, 32'h0);
      bus(1'b1, `OFS_CTRL, 32'h19);
      u_line_partner.send_char(8'h00, 1'b0, 1'b0, 2, 3);
      wait_word();
      check(rx_word, 12'h500, "break per char");
      rd_chk(`OFS_ERR, 32'hF, 32'h5, "frame and break");
      rd_chk(`OFS_RIS, 32'h780, 32'h280, "frame break irq");
      bus(1'b1, `OFS_ICR, 32'h7FF);
      bus(1'b1, `OFS_ERR, 32'h0);
      rx_fifo_full <= 1'b1;
      u_line_partner.send_char(8'h55, 1'b0, 1'b1, 0, 0);
      rd_chk(`OFS_ERR, 32'hF, 32'h8, "overrun at once");
      rx_fifo_full <= 1'b0;
      u_line_partner.send_char(8'h33, 1'b0, 1'b1, 0, 0);
      wait_word();
      check(rx_word, 12'h833, "overrun per char");
      bus(1'b1, `OFS_ERR, 32'h0);
      bus(1'b1, `OFS_IMASK, 32'h0);
      check(u_line_partner.tick_miss, 32'h0, "bit tick lost");
      bus(1'b1, `OFS_ICR, 32'h7FF);
   endtask

   task automatic t_tx_irq();
      @(posedge clk);
      modem_chg <= 4'hF;
      rx_level_evt <= 1'b1;
      rx_timeout_irq <= 1'b1;
      @(posedge clk);
      modem_chg <= 4'h0;
      rx_level_evt <= 1'b0;
      rx_timeout_irq <= 1'b0;
      rd_chk(`OFS_RIS, 32'h5F, 32'h5F, "event raw");
      check(irq, 1'b0, "masked events");
      bus(1'b1, `OFS_ICR, 32'h7FF);
      tx_fifo_thr <= 5'h04;
      tx_fifo_level <= 5'h06;
      step(3);
      tx_fifo_level <= 5'h05;
      rd_chk(`OFS_RIS, 32'h20, 32'h0, "above threshold");
      tx_fifo_level <= 5'h04;
      rd_chk(`OFS_RIS, 32'h20, 32'h20, "fell past threshold");
      bus(1'b1, `OFS_IMASK, 32'h20);
      step(2);
      check(irq, 1'b1, "tx irq out");
      rd_chk(`OFS_MIS, 32'h7FF, 32'h20, "masked status");
      bus(1'b1, `OFS_ICR, 32'h20);
      bus(1'b1, `OFS_CTRL, 32'h58);
      rd_chk(`OFS_CTRL, 32'h7F, 32'h58, "idle mode readback");
      tx_shift_busy <= 1'b1;
      tx_fifo_level <= 5'h00;
      rd_chk(`OFS_RIS, 32'h20, 32'h0, "shifter still busy");
      tx_shift_busy <= 1'b0;
      rd_chk(`OFS_RIS, 32'h20, 32'h20, "idle irq");
      rd_chk(`OFS_STAT, 32'h2, 32'h2, "idle status");
   endtask

   task automatic t_space();
      // With the clock enable low every flop holds, so the full level must not show yet.
      ce <= 1'b0;
      tx_fifo_full <= 1'b1;
      step(3);
      check(tx_space_avail, 1'b1, "held while disabled");
      ce <= 1'b1;
      step(3);
      check(tx_space_avail, 1'b0, "fifo full");
      rd_chk(`OFS_STAT, 32'h1, 32'h0, "stat full");
      tx_fifo_full <= 1'b0;
      step(3);
      check(tx_space_avail, 1'b1, "fifo space");
   endtask

   initial begin
      step(12);
      srst <= 1'b0;
      t_reset();
      t_tx_parity();
      t_smart();
      t_rx_errors();
      t_tx_irq();
      t_space();
      end_sim();
   end
endmodule
